// *** hw/cse_clock_ctrl.sv ***
// Operation
// [R1] Source code 1 routes the very-low-power oscillator to that clock.
// [R2] Osc1 low-frequency when mode bit 0; high-frequency only without osc2.
// [R3] Osc1 bypass powers amplifier down; input takes external clock.
// [R4] Osc1 pin function clear: both pins GPIO, oscillator disabled.
// [R5] At power-up osc1 is low-frequency but off until pins configured.
// [R6] Osc1 runs when a clock using code 0 is on, or force-off clear.
// [R7] Osc2 bypass powers it down; input external clock, output GPIO.
// [R8] Osc2 pin function clear: both pins GPIO, oscillator disabled.
// [R9] Osc2 runs when a clock using codes 5-7 is on, or force-off clear.
// [R10] DCO offers three fixed frequencies, usable by all three clocks.
// [R11] A DCO setting change is held four cycles before release.
// [R12] Peripherals raise a clock request when enabled and using it.
// [R13] A request overrides clock-off without changing the stored off bit.
// [R14] Request enables reset on; clearing ignores requests, not fail-safe.
// [R15] Auxiliary request enable matters only in the deepest sleep mode.
// [R16] Sub request enable matters when its clock is normally off.
// [R17] Requested clock with dead source raises fault; watchdog uses VLO.
// [R18] Code 3 selects the DCO for main and sub clocks.
// [R19] Gate opens on power mode, enabled request, or fail-safe request.
module cse_clock_ctrl #(
  parameter bit OSC2_PRESENT = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // CPU power mode bits.
  input wire logic aux_osc_disable_i,
  input wire logic processor_halt_i,
  input wire logic sub_clk_sleep_i,
  // Pin function bits of the oscillator input pins.
  input wire logic osc1_pin_func_i,
  input wire logic osc2_pin_func_i,
  // Clock requests.
  input wire logic aux_clk_request_i,
  input wire logic main_clk_request_i,
  input wire logic sub_clk_request_i,
  input wire logic [2:0] failsafe_request_i,
  // Oscillator health.
  input wire logic osc1_running_i,
  input wire logic osc2_running_i,
  // Oscillator 1 controls.
  output logic osc1_amp_en_o,
  output logic osc1_hf_mode_o,
  output logic [1:0] osc1_drive_strength_o,
  output logic osc1_ext_clk_en_o,
  output logic osc1_input_pin_gpio_o,
  output logic osc1_output_pin_gpio_o,
  // Oscillator 2 controls.
  output logic osc2_amp_en_o,
  output logic [1:0] osc2_drive_strength_o,
  output logic osc2_ext_clk_en_o,
  output logic osc2_input_pin_gpio_o,
  output logic osc2_output_pin_gpio_o,
  // DCO controls.
  output logic [1:0] dco_frequency_o,
  output logic dco_range_o,
  output logic dco_clk_hold_o,
  // System clock gates and routes.
  output logic aux_clk_gate_o,
  output logic main_clk_gate_o,
  output logic sub_clk_gate_o,
  output cse_pkg::cse_route_t aux_route_o,
  output cse_pkg::cse_route_t main_route_o,
  output cse_pkg::cse_route_t sub_route_o,
  // Fault reporting.
  output logic osc_fault_o,
  output logic wdt_vlo_fallback_o
);

  // Software control state.
  logic osc1_freq_mode_sel_r;
  logic osc1_bypass_en_r;
  logic osc1_force_off_r;
  logic [1:0] osc1_drive_strength_r;
  logic osc2_bypass_en_r;
  logic osc2_force_off_r;
  logic [1:0] osc2_drive_strength_r;
  logic sub_clk_disable_r;
  logic [2:0] sel_r [cse_pkg::NUM_CLK];
  logic [1:0] dco_frequency_select_r;
  logic dco_range_select_r;
  logic [2:0] request_enable_r;
  logic fault_r;

  // Per-clock working signals.
  logic [2:0] normal_on;
  logic [2:0] request;
  logic [2:0] gate_nxt;
  logic [2:0] gate_r;
  logic [2:0] use_osc1;
  logic [2:0] use_osc2;
  logic [2:0] src_dead;
  cse_pkg::cse_route_t route_nxt [cse_pkg::NUM_CLK];
  cse_pkg::cse_route_t route_r [cse_pkg::NUM_CLK];

  logic wr_ctrl;
  logic wr_sel;
  logic wr_dco;
  logic wr_reqen;
  logic wr_stat;
  logic [1:0] fsel_wr;
  logic fault_set;
  logic osc1_amp_nxt;
  logic osc2_amp_nxt;
  logic [15:0] rdata_nxt;

  // Write decode.
  assign wr_ctrl = reg_wr_i && (reg_addr_i == cse_pkg::CTRL_ADDR);
  assign wr_sel = reg_wr_i && (reg_addr_i == cse_pkg::SEL_ADDR);
  assign wr_dco = reg_wr_i && (reg_addr_i == cse_pkg::DCO_ADDR);
  assign wr_reqen = reg_wr_i && (reg_addr_i == cse_pkg::REQEN_ADDR);
  assign wr_stat = reg_wr_i && (reg_addr_i == cse_pkg::STAT_ADDR);

  // Oscillator control register; power-up leaves osc1 in low mode.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc1_freq_mode_sel_r <= cse_pkg::RST_OSC1_HF; // [R5]
      osc1_bypass_en_r <= 1'h0;
      osc1_force_off_r <= cse_pkg::RST_OSC1_OFF;
      osc1_drive_strength_r <= cse_pkg::RST_DRIVE;
      osc2_bypass_en_r <= 1'h0;
      osc2_force_off_r <= cse_pkg::RST_OSC2_OFF;
      osc2_drive_strength_r <= cse_pkg::RST_DRIVE;
      sub_clk_disable_r <= cse_pkg::RST_SUB_OFF;
    end else if (wr_ctrl) begin
      osc1_freq_mode_sel_r <= reg_wdata_i[cse_pkg::CTRL_OSC1_HF_BIT];
      osc1_bypass_en_r <= reg_wdata_i[cse_pkg::CTRL_OSC1_BYP_BIT];
      osc1_force_off_r <= reg_wdata_i[cse_pkg::CTRL_OSC1_OFF_BIT];
      osc1_drive_strength_r <=
        reg_wdata_i[cse_pkg::CTRL_OSC1_DRV_LSB +: 2];
      osc2_bypass_en_r <= reg_wdata_i[cse_pkg::CTRL_OSC2_BYP_BIT];
      osc2_force_off_r <= reg_wdata_i[cse_pkg::CTRL_OSC2_OFF_BIT];
      osc2_drive_strength_r <=
        reg_wdata_i[cse_pkg::CTRL_OSC2_DRV_LSB +: 2];
      sub_clk_disable_r <= reg_wdata_i[cse_pkg::CTRL_SUB_OFF_BIT];
    end
  end

  // Source select register.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_r[cse_pkg::CLK_AUX] <= cse_pkg::RST_AUX_SEL;
      sel_r[cse_pkg::CLK_MAIN] <= cse_pkg::RST_MAIN_SEL; // [R18]
      sel_r[cse_pkg::CLK_SUB] <= cse_pkg::RST_SUB_SEL;
    end else if (wr_sel) begin
      sel_r[cse_pkg::CLK_AUX] <= reg_wdata_i[cse_pkg::SEL_AUX_LSB +: 3];
      sel_r[cse_pkg::CLK_MAIN] <= reg_wdata_i[cse_pkg::SEL_MAIN_LSB +: 3];
      sel_r[cse_pkg::CLK_SUB] <= reg_wdata_i[cse_pkg::SEL_SUB_LSB +: 3];
    end
  end

  // DCO register; only three frequency codes exist, so higher ones clamp.
  assign fsel_wr = (reg_wdata_i[cse_pkg::DCO_FSEL_LSB +: 2] >
                    cse_pkg::DCO_FSEL_MAX) ? cse_pkg::DCO_FSEL_MAX :
                   reg_wdata_i[cse_pkg::DCO_FSEL_LSB +: 2]; // [R10]

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dco_frequency_select_r <= cse_pkg::RST_DCO_FSEL;
      dco_range_select_r <= cse_pkg::RST_DCO_RSEL;
    end else if (wr_dco) begin
      dco_frequency_select_r <= fsel_wr;
      dco_range_select_r <= reg_wdata_i[cse_pkg::DCO_RSEL_BIT];
    end
  end

  // Request enables start out enabled.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      request_enable_r <= cse_pkg::RST_REQEN; // [R14]
    end else if (wr_reqen) begin
      request_enable_r <= reg_wdata_i[2:0];
    end
  end

  // Normal power-mode condition and peripheral requests per clock.
  assign normal_on[cse_pkg::CLK_AUX] = !aux_osc_disable_i; // [R15]
  assign normal_on[cse_pkg::CLK_MAIN] = !processor_halt_i;
  assign normal_on[cse_pkg::CLK_SUB] =
    !sub_clk_disable_r && !sub_clk_sleep_i; // [R16]
  assign request = {sub_clk_request_i, main_clk_request_i,
                    aux_clk_request_i}; // [R12]

  // Gate, route and source use for each system clock.
  for (genvar i = 0; i < cse_pkg::NUM_CLK; i++) begin : g_clk
    always_comb begin
      unique case (sel_r[i])
        cse_pkg::SRC_OSC1: route_nxt[i] = cse_pkg::ROUTE_OSC1;
        cse_pkg::SRC_VLO: route_nxt[i] = cse_pkg::ROUTE_VLO; // [R1]
        cse_pkg::SRC_DCO: route_nxt[i] = cse_pkg::ROUTE_DCO; // [R18] [R10]
        3'h5, 3'h6, 3'h7: route_nxt[i] = OSC2_PRESENT ?
          cse_pkg::ROUTE_OSC2 : cse_pkg::ROUTE_NONE;
        default: route_nxt[i] = cse_pkg::ROUTE_NONE;
      endcase
    end

    // Requests override clock-off without touching the stored off bits.
    assign gate_nxt[i] = normal_on[i] ||
      (request[i] && request_enable_r[i]) || // [R13] [R14]
      failsafe_request_i[i]; // [R19]
    assign use_osc1[i] = gate_nxt[i] && (sel_r[i] == cse_pkg::SRC_OSC1);
    assign use_osc2[i] = gate_nxt[i] && (sel_r[i] >= cse_pkg::SRC_OSC2_LO);
    assign src_dead[i] =
      ((route_nxt[i] == cse_pkg::ROUTE_OSC1) && !osc1_running_i) ||
      ((route_nxt[i] == cse_pkg::ROUTE_OSC2) && !osc2_running_i);

    // Registered gate and route.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        gate_r[i] <= 1'h0;
        route_r[i] <= cse_pkg::ROUTE_NONE;
      end else begin
        gate_r[i] <= gate_nxt[i]; // [R19]
        route_r[i] <= route_nxt[i];
      end
    end
  end

  // Oscillator enables, gated by pin function and bypass.
  assign osc1_amp_nxt = osc1_pin_func_i && !osc1_bypass_en_r && // [R4] [R3]
    ((|use_osc1) || !osc1_force_off_r); // [R6]
  assign osc2_amp_nxt = OSC2_PRESENT && osc2_pin_func_i && // [R8]
    !osc2_bypass_en_r && ((|use_osc2) || !osc2_force_off_r); // [R7] [R9]

  // Oscillator 1 pin and mode outputs.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc1_amp_en_o <= 1'h0;
      osc1_hf_mode_o <= 1'h0;
      osc1_drive_strength_o <= cse_pkg::RST_DRIVE;
      osc1_ext_clk_en_o <= 1'h0;
      osc1_input_pin_gpio_o <= 1'h1;
      osc1_output_pin_gpio_o <= 1'h1;
    end else begin
      osc1_amp_en_o <= osc1_amp_nxt;
      osc1_hf_mode_o <= osc1_freq_mode_sel_r && !OSC2_PRESENT; // [R2]
      osc1_drive_strength_o <= osc1_drive_strength_r;
      osc1_ext_clk_en_o <= osc1_pin_func_i && osc1_bypass_en_r; // [R3]
      osc1_input_pin_gpio_o <= !osc1_pin_func_i; // [R4]
      osc1_output_pin_gpio_o <= !osc1_pin_func_i || osc1_bypass_en_r;
    end
  end

  // Oscillator 2 pin outputs.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc2_amp_en_o <= 1'h0;
      osc2_drive_strength_o <= cse_pkg::RST_DRIVE;
      osc2_ext_clk_en_o <= 1'h0;
      osc2_input_pin_gpio_o <= 1'h1;
      osc2_output_pin_gpio_o <= 1'h1;
    end else begin
      osc2_amp_en_o <= osc2_amp_nxt;
      osc2_drive_strength_o <= osc2_drive_strength_r;
      osc2_ext_clk_en_o <= osc2_pin_func_i && osc2_bypass_en_r; // [R7]
      osc2_input_pin_gpio_o <= !osc2_pin_func_i; // [R8]
      osc2_output_pin_gpio_o <= !osc2_pin_func_i || osc2_bypass_en_r;
    end
  end

  // DCO settling hold.
  cse_dco_hold u_dco_hold (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .fsel_i(dco_frequency_select_r),
    .rsel_i(dco_range_select_r),
    .fsel_o(dco_frequency_o),
    .rsel_o(dco_range_o),
    .hold_o(dco_clk_hold_o)
  );

  // Sticky fault: a set in the clearing cycle wins.
  assign fault_set = |(gate_nxt & src_dead);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r <= 1'h0;
      wdt_vlo_fallback_o <= 1'h0;
    end else begin
      if (fault_set) begin
        fault_r <= 1'h1; // [R17]
      end else if (wr_stat && reg_wdata_i[cse_pkg::STAT_FAULT_BIT]) begin
        fault_r <= 1'h0;
      end
      wdt_vlo_fallback_o <= |(failsafe_request_i & src_dead); // [R17]
    end
  end

  // Register read mux; data stands one cycle after the read strobe.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        cse_pkg::CTRL_ADDR: begin
          rdata_nxt[cse_pkg::CTRL_OSC1_HF_BIT] = osc1_freq_mode_sel_r;
          rdata_nxt[cse_pkg::CTRL_OSC1_BYP_BIT] = osc1_bypass_en_r;
          rdata_nxt[cse_pkg::CTRL_OSC1_OFF_BIT] = osc1_force_off_r;
          rdata_nxt[cse_pkg::CTRL_OSC1_DRV_LSB +: 2] = osc1_drive_strength_r;
          rdata_nxt[cse_pkg::CTRL_OSC2_BYP_BIT] = osc2_bypass_en_r;
          rdata_nxt[cse_pkg::CTRL_OSC2_OFF_BIT] = osc2_force_off_r;
          rdata_nxt[cse_pkg::CTRL_OSC2_DRV_LSB +: 2] = osc2_drive_strength_r;
          rdata_nxt[cse_pkg::CTRL_SUB_OFF_BIT] = sub_clk_disable_r;
        end
        cse_pkg::SEL_ADDR: begin
          rdata_nxt[cse_pkg::SEL_AUX_LSB +: 3] = sel_r[cse_pkg::CLK_AUX];
          rdata_nxt[cse_pkg::SEL_MAIN_LSB +: 3] = sel_r[cse_pkg::CLK_MAIN];
          rdata_nxt[cse_pkg::SEL_SUB_LSB +: 3] = sel_r[cse_pkg::CLK_SUB];
        end
        cse_pkg::DCO_ADDR: begin
          rdata_nxt[cse_pkg::DCO_FSEL_LSB +: 2] = dco_frequency_select_r;
          rdata_nxt[cse_pkg::DCO_RSEL_BIT] = dco_range_select_r;
        end
        cse_pkg::REQEN_ADDR: rdata_nxt[2:0] = request_enable_r;
        cse_pkg::STAT_ADDR: begin
          rdata_nxt[cse_pkg::STAT_FAULT_BIT] = fault_r;
          rdata_nxt[cse_pkg::STAT_OSC1_BIT] = osc1_amp_en_o;
          rdata_nxt[cse_pkg::STAT_OSC2_BIT] = osc2_amp_en_o;
          rdata_nxt[cse_pkg::STAT_HOLD_BIT] = dco_clk_hold_o;
          rdata_nxt[cse_pkg::STAT_GATE_LSB +: 3] = gate_r;
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Output mapping from registered per-clock state.
  assign osc_fault_o = fault_r;
  assign aux_clk_gate_o = gate_r[cse_pkg::CLK_AUX];
  assign main_clk_gate_o = gate_r[cse_pkg::CLK_MAIN];
  assign sub_clk_gate_o = gate_r[cse_pkg::CLK_SUB];
  assign aux_route_o = route_r[cse_pkg::CLK_AUX];
  assign main_route_o = route_r[cse_pkg::CLK_MAIN];
  assign sub_route_o = route_r[cse_pkg::CLK_SUB];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Code 1 on the auxiliary select routes the VLO.
  property p_vlo_route;
    sel_r[cse_pkg::CLK_AUX] == cse_pkg::SRC_VLO |=>
      aux_route_o == cse_pkg::ROUTE_VLO;
  endproperty
  a_vlo_route: assert property (p_vlo_route) // [R1]
    else $error("VLO not routed for code 1.");

  property p_osc1_hf;
    osc1_hf_mode_o == ($past(osc1_freq_mode_sel_r) && !OSC2_PRESENT);
  endproperty
  a_osc1_hf: assert property (p_osc1_hf) // [R2]
    else $error("Osc1 high mode without cause.");

  property p_osc1_bypass;
    osc1_pin_func_i && osc1_bypass_en_r |=>
      !osc1_amp_en_o && osc1_ext_clk_en_o && osc1_output_pin_gpio_o;
  endproperty
  a_osc1_bypass: assert property (p_osc1_bypass) // [R3]
    else $error("Osc1 bypass not applied.");

  property p_osc1_pins;
    !osc1_pin_func_i |=> !osc1_amp_en_o && osc1_input_pin_gpio_o &&
      osc1_output_pin_gpio_o;
  endproperty
  a_osc1_pins: assert property (p_osc1_pins) // [R4]
    else $error("Osc1 pins not released to GPIO.");

  sequence s_osc1_wanted;
    osc1_pin_func_i && !osc1_bypass_en_r &&
      (!osc1_force_off_r || (sel_r[cse_pkg::CLK_AUX] ==
       cse_pkg::SRC_OSC1 && !aux_osc_disable_i));
  endsequence
  property p_osc1_enable;
    s_osc1_wanted |=> osc1_amp_en_o;
  endproperty
  a_osc1_enable: assert property (p_osc1_enable) // [R6]
    else $error("Osc1 not enabled.");

  sequence s_osc2_wanted;
    OSC2_PRESENT && osc2_pin_func_i && !osc2_bypass_en_r &&
      sel_r[cse_pkg::CLK_MAIN] >= cse_pkg::SRC_OSC2_LO && !processor_halt_i;
  endsequence
  property p_osc2_enable;
    s_osc2_wanted |=> osc2_amp_en_o;
  endproperty
  a_osc2_enable: assert property (p_osc2_enable) // [R9]
    else $error("Osc2 not enabled.");

  property p_osc2_bypass;
    osc2_bypass_en_r || !osc2_pin_func_i |=> !osc2_amp_en_o &&
      osc2_output_pin_gpio_o;
  endproperty
  a_osc2_bypass: assert property (p_osc2_bypass) // [R7]
    else $error("Osc2 running in bypass or GPIO.");

  property p_req_gate;
    main_clk_request_i && request_enable_r[cse_pkg::CLK_MAIN] |=>
      main_clk_gate_o;
  endproperty
  a_req_gate: assert property (p_req_gate) // [R13]
    else $error("Main request did not open the gate.");

  property p_sub_gate;
    sub_clk_gate_o |-> $past(normal_on[cse_pkg::CLK_SUB]) ||
      $past(failsafe_request_i[cse_pkg::CLK_SUB]) ||
      ($past(sub_clk_request_i) && $past(request_enable_r[2]));
  endproperty
  a_sub_gate: assert property (p_sub_gate) // [R16]
    else $error("Sub gate open without cause.");

  sequence s_dead_use;
    fault_set;
  endsequence
  property p_fault;
    s_dead_use |=> osc_fault_o ##1 (osc_fault_o || $past(wr_stat));
  endproperty
  a_fault: assert property (p_fault) // [R17]
    else $error("Oscillator fault not raised.");

endmodule

// *** hw/cse_dco_hold.sv ***
module cse_dco_hold (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Requested DCO setting.
  input wire logic [1:0] fsel_i,
  input wire logic rsel_i,
  // Released DCO setting and hold flag.
  output logic [1:0] fsel_o,
  output logic rsel_o,
  output logic hold_o
);

  typedef enum logic {HOLD_IDLE, HOLD_WAIT} cse_hold_state_t;

  cse_hold_state_t state_r;
  logic [2:0] pend_r;
  logic [2:0] cnt_r;
  logic [2:0] setting;
  logic changed;

  assign setting = {rsel_i, fsel_i};
  assign changed = (setting != pend_r);

  // Any new setting restarts the hold; release comes after four cycles.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= HOLD_IDLE;
      pend_r <= {cse_pkg::RST_DCO_RSEL, cse_pkg::RST_DCO_FSEL};
      cnt_r <= 3'h0;
      hold_o <= 1'h0;
      fsel_o <= cse_pkg::RST_DCO_FSEL;
      rsel_o <= cse_pkg::RST_DCO_RSEL;
    end else begin
      unique case (state_r)
        HOLD_IDLE: begin
          if (changed) begin // [R11]
            state_r <= HOLD_WAIT;
            pend_r <= setting;
            cnt_r <= 3'h0;
            hold_o <= 1'h1;
          end
        end
        HOLD_WAIT: begin
          if (changed) begin // [R11]
            pend_r <= setting;
            cnt_r <= 3'h0;
          end else if (cnt_r == 3'(cse_pkg::DCO_HOLD_CYCLES - 3'h1)) begin
            state_r <= HOLD_IDLE;
            hold_o <= 1'h0;
            {rsel_o, fsel_o} <= pend_r; // [R11]
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // The hold always lasts at least four cycles.
  property p_hold_len;
    $fell(hold_o) |-> $past(hold_o, 1) && $past(hold_o, 2) &&
      $past(hold_o, 3) && $past(hold_o, 4);
  endproperty
  a_hold_len: assert property (p_hold_len) // [R11]
    else $error("DCO hold shorter than four cycles.");

  // The released setting never moves while held.
  property p_hold_freeze;
    hold_o && $past(hold_o) |-> $stable({rsel_o, fsel_o});
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) // [R11]
    else $error("DCO setting released during hold.");

endmodule

// *** hw/cse_pkg.sv ***
package cse_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word addresses.
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] SEL_ADDR = 4'h1;
  localparam logic [3:0] DCO_ADDR = 4'h2;
  localparam logic [3:0] REQEN_ADDR = 4'h3;
  localparam logic [3:0] STAT_ADDR = 4'h4;

  // Oscillator control register fields.
  localparam int CTRL_OSC1_HF_BIT = 0;
  localparam int CTRL_OSC1_BYP_BIT = 1;
  localparam int CTRL_OSC1_OFF_BIT = 2;
  localparam int CTRL_OSC1_DRV_LSB = 3;
  localparam int CTRL_OSC2_BYP_BIT = 5;
  localparam int CTRL_OSC2_OFF_BIT = 6;
  localparam int CTRL_OSC2_DRV_LSB = 7;
  localparam int CTRL_SUB_OFF_BIT = 9;

  // Source select register fields, one three-bit field per clock.
  localparam int SEL_AUX_LSB = 0;
  localparam int SEL_MAIN_LSB = 4;
  localparam int SEL_SUB_LSB = 8;

  // DCO register fields.
  localparam int DCO_FSEL_LSB = 0;
  localparam int DCO_RSEL_BIT = 2;

  // Status register fields.
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_OSC1_BIT = 1;
  localparam int STAT_OSC2_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_GATE_LSB = 4;

  // Reset values.
  localparam logic RST_OSC1_HF = 1'h0;
  localparam logic RST_OSC1_OFF = 1'h1;
  localparam logic RST_OSC2_OFF = 1'h1;
  localparam logic RST_SUB_OFF = 1'h0;
  localparam logic [1:0] RST_DRIVE = 2'h3;
  localparam logic [2:0] RST_AUX_SEL = 3'h0;
  localparam logic [2:0] RST_MAIN_SEL = 3'h3;
  localparam logic [2:0] RST_SUB_SEL = 3'h3;
  localparam logic [1:0] RST_DCO_FSEL = 2'h0;
  localparam logic RST_DCO_RSEL = 1'h0;
  localparam logic [2:0] RST_REQEN = 3'h7;

  // Clock indexes and source codes.
  localparam int NUM_CLK = 3;
  localparam int CLK_AUX = 0;
  localparam int CLK_MAIN = 1;
  localparam int CLK_SUB = 2;
  localparam logic [2:0] SRC_OSC1 = 3'h0;
  localparam logic [2:0] SRC_VLO = 3'h1;
  localparam logic [2:0] SRC_DCO = 3'h3;
  localparam logic [2:0] SRC_OSC2_LO = 3'h5;
  localparam logic [1:0] DCO_FSEL_MAX = 2'h2;

  // DCO settling hold, in cycles.
  localparam logic [2:0] DCO_HOLD_CYCLES = 3'h4;

  // Clock routing choices.
  typedef enum logic [2:0] {
    ROUTE_NONE,
    ROUTE_OSC1,
    ROUTE_VLO,
    ROUTE_DCO,
    ROUTE_OSC2
  } cse_route_t;

endpackage

// *** testbench/cse_periph_model.sv ***
module cse_periph_model (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Clocks in use by enabled peripherals: aux, main, sub.
  input wire logic [2:0] use_i,
  // Request lines towards the clock block.
  output logic [2:0] req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A request follows the peripheral's setup one cycle later.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) req_o <= 3'h0;
    else req_o <= use_i;
  end
endmodule

// *** testbench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic aod = 1'b0;
  logic halt = 1'b0;
  logic sslp = 1'b0;
  logic pf1 = 1'b0;
  logic pf2 = 1'b0;
  logic amp2, ext2, gi2, go2;
  logic [1:0] drv2;
  logic [2:0] use_clk = 3'h0;
  logic [2:0] fs = 3'h0;
  logic run1 = 1'b1;
  logic [2:0] req, gate;
  logic [15:0] rdata, d;
  logic [1:0] drv1, freq;
  logic amp1, hf, ext1, gi1, go1, rng, hold, fault, fb;
  cse_pkg::cse_route_t ra, rm, rs;
  int bad_count = 0;
  int compares = 0;
  int n;
  // Free-running core clock, 8 ns period.
  always #4 clk = ~clk;
  cse_periph_model u_periph (.core_clk_i(clk), .rst_n_i(rst_n),
    .use_i(use_clk), .req_o(req));
  cse_clock_ctrl u_dut (.core_clk_i(clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .aux_osc_disable_i(aod), .processor_halt_i(halt),
    .sub_clk_sleep_i(sslp), .osc1_pin_func_i(pf1), .osc2_pin_func_i(pf2),
    .aux_clk_request_i(req[0]), .main_clk_request_i(req[1]),
    .sub_clk_request_i(req[2]), .failsafe_request_i(fs),
    .osc1_running_i(run1), .osc2_running_i(1'b1), .osc1_amp_en_o(amp1),
    .osc1_hf_mode_o(hf), .osc1_drive_strength_o(drv1),
    .osc1_ext_clk_en_o(ext1), .osc1_input_pin_gpio_o(gi1),
    .osc1_output_pin_gpio_o(go1), .osc2_amp_en_o(amp2),
    .osc2_drive_strength_o(drv2), .osc2_ext_clk_en_o(ext2),
    .osc2_input_pin_gpio_o(gi2), .osc2_output_pin_gpio_o(go2),
    .dco_frequency_o(freq), .dco_range_o(rng), .dco_clk_hold_o(hold),
    .aux_clk_gate_o(gate[0]), .main_clk_gate_o(gate[1]),
    .sub_clk_gate_o(gate[2]), .aux_route_o(ra), .main_route_o(rm),
    .sub_route_o(rs), .osc_fault_o(fault), .wdt_vlo_fallback_o(fb));
  // Compares one result with the model's value.
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One-cycle register write.
  task automatic wreg(logic [3:0] a, logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle register read; data stands only in the next cycle.
  task automatic rreg(logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Lets c edges pass, then settles.
  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Expected route for a source code.
  function automatic logic [15:0] rte(int c);
    case (c)
      0: return 16'(cse_pkg::ROUTE_OSC1);
      1: return 16'(cse_pkg::ROUTE_VLO);
      3: return 16'(cse_pkg::ROUTE_DCO);
      5, 6, 7: return 16'(cse_pkg::ROUTE_OSC2);
      default: return 16'(cse_pkg::ROUTE_NONE);
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    #40000;
    bad_count++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    n = $urandom(32'h40c4a48a);
    tick(2);
    rst_n <= 1'b1;
    rreg(cse_pkg::SEL_ADDR, d);
    chk("sel_rst", 16'h0330, d);
    rreg(cse_pkg::REQEN_ADDR, d);
    chk("reqen_rst", 16'h0007, d);
    rreg(cse_pkg::CTRL_ADDR, d);
    chk("ctrl_rst", 16'h01dc, d);
    rreg(4'hf, d);
    chk("unmapped", 16'h0, d);
    chk("amp1_pwrup", 16'h0, 16'(amp1));
    chk("gpio_pwrup", 16'h1, 16'(gi1 & go1));
    n = $urandom & 3;
    wreg(cse_pkg::CTRL_ADDR, 16'h01c5 | 16'(n << 3));
    tick(2);
    chk("hf_mode", 16'h0, 16'(hf));
    chk("drive1", 16'(n), 16'(drv1));
    for (int c = 0; c < 8; c++) begin
      wreg(cse_pkg::SEL_ADDR, 16'(c | (c << 4) | (c << 8)));
      tick(2);
      chk("aux_route", rte(c), 16'(ra));
      chk("main_route", rte(c), 16'(rm));
      chk("sub_route", rte(c), 16'(rs));
    end
    wreg(cse_pkg::SEL_ADDR, 16'h0330);
    pf1 <= 1'b1;
    tick(2);
    chk("amp1_sel", 16'h1, 16'(amp1));
    chk("gpio_osc", 16'h0, 16'(gi1 | go1));
    aod <= 1'b1;
    tick(2);
    chk("amp1_off", 16'h0, 16'(amp1));
    wreg(cse_pkg::CTRL_ADDR, 16'h01d8);
    tick(2);
    chk("amp1_force", 16'h1, 16'(amp1));
    wreg(cse_pkg::CTRL_ADDR, 16'h01da);
    tick(2);
    chk("bypass", 16'h6, {13'h0, ext1, go1, amp1});
    wreg(cse_pkg::CTRL_ADDR, 16'h01d8);
    pf1 <= 1'b0;
    tick(2);
    chk("pin_gpio", 16'h6, {13'h0, gi1, go1, amp1});
    halt <= 1'b1;
    sslp <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      use_clk <= 3'(1 << i);
      tick(3);
      chk("gate_req", 16'h1, 16'(gate[i]));
      wreg(cse_pkg::REQEN_ADDR, 16'(7 & ~(1 << i)));
      tick(2);
      chk("gate_noen", 16'h0, 16'(gate[i]));
      fs <= 3'(1 << i);
      tick(2);
      chk("gate_fs", 16'h1, 16'(gate[i]));
      fs <= 3'h0;
      use_clk <= 3'h0;
      wreg(cse_pkg::REQEN_ADDR, 16'h7);
    end
    halt <= 1'b0;
    sslp <= 1'b0;
    aod <= 1'b0;
    for (int v = 1; v < 8; v += 6) begin
      wreg(cse_pkg::DCO_ADDR, 16'(v));
      tick(1);
      n = 0;
      while (hold === 1'b1 && n < 20) begin
        n++;
        tick(1);
      end
      chk("hold_len", 16'h4, 16'(n));
      chk("dco_f", 16'((v & 3) > 2 ? 2 : (v & 3)), 16'(freq));
      chk("dco_r", 16'(v >> 2), 16'(rng));
    end
    // Main clock on the second oscillator, then bypass, then GPIO pins.
    wreg(cse_pkg::SEL_ADDR, 16'h0350);
    pf2 <= 1'b1;
    tick(2);
    chk("amp2_sel", 16'h1, 16'(amp2));
    chk("gpio2_osc", 16'h0, 16'(gi2 | go2));
    wreg(cse_pkg::CTRL_ADDR, 16'h01f8);
    tick(2);
    chk("bypass2", 16'h6, {13'h0, ext2, go2, amp2});
    wreg(cse_pkg::CTRL_ADDR, 16'h01d8);
    pf2 <= 1'b0;
    tick(2);
    chk("pin_gpio2", 16'h6, {13'h0, gi2, go2, amp2});
    chk("drive2", 16'h3, 16'(drv2));
    run1 <= 1'b0;
    tick(3);
    chk("fault", 16'h1, 16'(fault));
    fs <= 3'h1;
    tick(3);
    chk("wdt_fb", 16'h1, 16'(fb));
    rreg(cse_pkg::STAT_ADDR, d);
    chk("stat", 16'h0071, d);
    run1 <= 1'b1;
    fs <= 3'h0;
    wreg(cse_pkg::STAT_ADDR, 16'h1);
    tick(2);
    chk("fault_clr", 16'h0, 16'(fault));
    tally_and_finish();
  end
endmodule
